// file: hdl/pvic_top.sv
// vectored interrupt controller with AXI4-Lite register port
`default_nettype none
module pvic_top
	import pvic_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [13:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [13:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wdt_req,
	input wire logic posc_fail_req,
	input wire logic wosc_fail_req,
	input wire logic illegal_instr_req,
	input wire logic timer1_req,
	input wire logic timer0_req,
	input wire logic uart_rx_req,
	input wire logic uart_tx_req,
	input wire logic adc_req,
	input wire logic [7:0] porta_pinx_req,
	input wire logic cmp_req,
	input wire logic [3:2] portd_pinx_req,
	input wire logic [3:1] portc_pinx_req,
	input wire logic disable_irq_instr,
	input wire logic trap_instr,
	input wire logic cpu_ack,
	output logic irq_to_cpu,
	output logic [15:0] vector_addr,
	output logic [7:0] vector_byte_even,
	output logic [7:0] vector_byte_odd,
	output logic vector_valid,
	output logic global_irq_enable
);
	typedef struct packed {
		logic [NSRC-1:0] pend;
		logic [NSRC*2-1:0] level;
		logic gie;
		logic irq;
		logic [15:0] vec;
		logic vec_valid;
		logic aw_got;
		logic [13:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pvic_state_s;

	pvic_state_s st;
	pvic_state_s next_st;
	pvic_arb_if arb_bus();
	logic [NSRC-1:0] pulse;
	logic [NSRC-1:0] sw_clr;
	logic [NSRC-1:0] sw_set;
	logic [NSRC-1:0] ack_clr;
	logic [NSRC-1:0] trap_mask;
	logic do_write;
	logic [7:0] wbyte;
	logic trap_hit;

	// ================================================================
	// request pulses gathered in table order
	always_comb begin
		pulse[0] = wdt_req;
		pulse[1] = posc_fail_req;
		pulse[2] = wosc_fail_req;
		pulse[3] = illegal_instr_req;
		pulse[4] = timer1_req;
		pulse[5] = timer0_req;
		pulse[6] = uart_rx_req;
		pulse[7] = uart_tx_req;
		pulse[8] = adc_req;
		pulse[9] = porta_pinx_req[7];
		pulse[10] = porta_pinx_req[6] | cmp_req;
		pulse[11] = porta_pinx_req[5];
		pulse[12] = porta_pinx_req[4];
		pulse[13] = porta_pinx_req[3] | portd_pinx_req[3];
		pulse[14] = porta_pinx_req[2] | portd_pinx_req[2];
		pulse[15] = porta_pinx_req[1];
		pulse[16] = porta_pinx_req[0];
		pulse[17] = portc_pinx_req[3];
		pulse[18] = portc_pinx_req[2];
		pulse[19] = portc_pinx_req[1];
	end

	// ================================================================
	// arbiter sees only pending sources
	always_comb begin
		arb_bus.req.pending = st.pend;
		arb_bus.req.level = st.level;
	end

	pvic_arb u_arb (
		.arb(arb_bus)
	);

	// ================================================================
	// software write decode; pending registers map to bit ranges
	assign do_write = st.aw_got && st.w_got && !st.bvalid;
	assign wbyte = st.w_strb[0] ? st.w_data[7:0] : 8'h00;
	always_comb begin
		sw_clr = '0;
		sw_set = '0;
		if (do_write && st.w_strb[0]) begin
			if (st.aw_addr == ADDR_PEND_ONE) begin
				// port A bits: 7 -> idx 9 ... 0 -> idx 16
				for (int b = 0; b < 8; b++) begin
					sw_set[16-b] = wbyte[b];
					sw_clr[16-b] = !wbyte[b];
				end
			end else if (st.aw_addr == ADDR_PEND_TWO) begin
				// bits 0..4 -> idx 4..8, bits 5..7 -> idx 17..19; byte lanes 1..3 unused
				for (int b = 0; b < 5; b++) begin
					sw_set[4+b] = wbyte[b];
					sw_clr[4+b] = !wbyte[b];
				end
				for (int b = 5; b < 8; b++) begin
					sw_set[12+b] = wbyte[b];
					sw_clr[12+b] = !wbyte[b];
				end
			end
		end
	end

	// acknowledge clears only the source the arbiter picks in the ack cycle
	always_comb begin
		ack_clr = '0;
		if (cpu_ack && st.vec_valid && arb_bus.found) begin
			ack_clr[arb_bus.winner] = 1'b1;
		end
	end

	assign trap_mask = {{(NSRC - NTRAP){1'b0}}, 4'b1110};
	assign trap_hit = |(pulse & trap_mask);

	// ================================================================
	// next state
	always_comb begin
		next_st = st;
		// pulse wins over any clear; capture ignores gie
		next_st.pend = ((st.pend & ~sw_clr & ~ack_clr) | sw_set) |
			pulse;
		// traps are never masked by level; watchdog is level 3 too
		if (do_write && st.aw_addr == ADDR_PRIO_LO) begin
			for (int i = 0; i < 4; i++) begin
				if (st.w_strb[i]) begin
					next_st.level[8*i +: 8] = st.w_data[8*i +: 8];
				end
			end
		end
		if (do_write && st.aw_addr == ADDR_PRIO_HI && st.w_strb[0]) begin
			next_st.level[39:32] = st.w_data[7:0];
		end
		if (do_write && st.aw_addr == ADDR_CTRL && st.w_strb[0]) begin
			next_st.gie = st.w_data[CTRL_EN_BIT];
		end
		if (disable_irq_instr || trap_instr || trap_hit ||
			(cpu_ack && st.vec_valid)) begin
			next_st.gie = 1'b0;
		end
		// forward irq and flag vector valid only while enabled; vec itself always updates
		next_st.irq = st.gie && arb_bus.found;
		next_st.vec_valid = st.gie && arb_bus.found;
		next_st.vec = arb_bus.found ?
			VEC_TABLE[16*arb_bus.winner +: 16] : VEC_NONE;
		// ----- AXI write channel
		if (s_axi_awvalid && !st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = (st.aw_addr == ADDR_PEND_ONE ||
				st.aw_addr == ADDR_PEND_TWO ||
				st.aw_addr == ADDR_CTRL ||
				st.aw_addr == ADDR_PRIO_LO ||
				st.aw_addr == ADDR_PRIO_HI ||
				st.aw_addr == ADDR_VECTOR) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
		end
		// ----- AXI read channel
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				ADDR_PEND_ONE: begin
					for (int b = 0; b < 8; b++) begin
						next_st.rdata[b] = st.pend[16-b];
					end
				end
				ADDR_PEND_TWO: begin
					next_st.rdata[4:0] = st.pend[8:4];
					next_st.rdata[7:5] = st.pend[19:17];
				end
				ADDR_CTRL: next_st.rdata[CTRL_EN_BIT] = st.gie;
				ADDR_PRIO_LO: next_st.rdata = st.level[31:0];
				ADDR_PRIO_HI: next_st.rdata[7:0] = st.level[39:32];
				ADDR_VECTOR: next_st.rdata = {15'h0000, st.vec_valid, st.vec};
				default: next_st.rresp = RESP_SLVERR;
			endcase
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// ================================================================
	// state register; reset also selects the reset vector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.level <= {RST_PRIO, RST_PRIO, 8'h55};
			st.vec <= VEC_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ================================================================
	// outputs straight from the state register
	assign s_axi_awready = !st.aw_got;
	assign s_axi_wready = !st.w_got;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign irq_to_cpu = st.irq;
	assign vector_addr = st.vec;
	assign vector_byte_even = st.vec[15:8];
	assign vector_byte_odd = st.vec[7:0];
	assign vector_valid = st.vec_valid;
	assign global_irq_enable = st.gie;
endmodule
`default_nettype wire

// file: hdl/pvic_pkg.sv
// constants and types shared by the vectored interrupt controller
`default_nettype none
package pvic_pkg;
	// ================================================================
	// register map (byte addresses; printed offset is not word aligned)
	localparam logic [11:0] REG_IDX_PEND_ONE = 12'hfc3;
	localparam logic [11:0] REG_IDX_PEND_TWO = 12'hfc4;
	localparam logic [11:0] REG_IDX_CTRL = 12'hfc5;
	localparam logic [11:0] REG_IDX_PRIO_LO = 12'hfc6;
	localparam logic [11:0] REG_IDX_PRIO_HI = 12'hfc7;
	localparam logic [11:0] REG_IDX_VECTOR = 12'hfc8;
	localparam logic [13:0] ADDR_PEND_ONE = {REG_IDX_PEND_ONE, 2'b00};
	localparam logic [13:0] ADDR_PEND_TWO = {REG_IDX_PEND_TWO, 2'b00};
	localparam logic [13:0] ADDR_CTRL = {REG_IDX_CTRL, 2'b00};
	localparam logic [13:0] ADDR_PRIO_LO = {REG_IDX_PRIO_LO, 2'b00};
	localparam logic [13:0] ADDR_PRIO_HI = {REG_IDX_PRIO_HI, 2'b00};
	localparam logic [13:0] ADDR_VECTOR = {REG_IDX_VECTOR, 2'b00};
	localparam logic [7:0] RST_PEND = 8'h00;
	localparam logic [15:0] RST_PRIO = 16'h5555;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ================================================================
	// sources in fixed table order, index 0 ranks first
	localparam int NSRC = 20;
	localparam int NTRAP = 4;
	localparam int PEND_TWO_BASE = 12;
	localparam logic [15:0] VEC_RESET = 16'h0002;
	localparam logic [15:0] VEC_NONE = 16'h0000;
	localparam logic [1:0] LVL_TOP = 2'd3;
	localparam logic [NSRC*16-1:0] VEC_TABLE = {
		16'h0034, 16'h0032, 16'h0030,
		16'h0026, 16'h0024, 16'h0022, 16'h0020,
		16'h001e, 16'h001c, 16'h001a, 16'h0018,
		16'h0016, 16'h0010, 16'h000e, 16'h000c, 16'h000a,
		16'h0006, 16'h003c, 16'h003a, 16'h0004};
	// ================================================================
	// request bundle (pending and level) from top to arbiter
	typedef struct packed {
		logic [NSRC-1:0] pending;
		logic [NSRC*2-1:0] level;
	} pvic_arb_in_s;
endpackage
`default_nettype wire

// file: hdl/pvic_arb_if.sv
// bundle between the controller and its arbiter
`default_nettype none
interface pvic_arb_if;
	import pvic_pkg::*;
	pvic_arb_in_s req;
	logic found;
	logic [4:0] winner;
	modport ctrl (output req, input found, input winner);
	modport arb (input req, output found, output winner);
endinterface
`default_nettype wire

// file: hdl/pvic_arb.sv
// priority arbiter: level first, then table order
`default_nettype none
module pvic_arb
	import pvic_pkg::*;
(
	pvic_arb_if.arb arb
);
	logic [NSRC-1:0] hit3;
	logic [NSRC-1:0] hit2;
	logic [NSRC-1:0] hit1;
	logic [NSRC-1:0] pick;
	// ================================================================
	// per-source level decode
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_src
			logic [1:0] lv;
			// traps and watchdog always sit at the top level
			assign lv = (g < NTRAP) ? LVL_TOP :
				arb.req.level[2*g +: 2];
			assign hit3[g] = arb.req.pending[g] && lv == 2'd3;
			assign hit2[g] = arb.req.pending[g] && lv == 2'd2;
			assign hit1[g] = arb.req.pending[g] && lv == 2'd1;
		end
	endgenerate
	// ================================================================
	// level 3 beats 2 beats 1; level 0 means source masked
	always_comb begin
		if (|hit3) begin
			pick = hit3;
		end else if (|hit2) begin
			pick = hit2;
		end else begin
			pick = hit1;
		end
	end
	always_comb begin
		arb.found = |pick;
		arb.winner = 5'd0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pick[i]) begin
				arb.winner = 5'(i);
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/pvic_cpu_model.sv
// processor core model that accepts vectored interrupts
`default_nettype none
module pvic_cpu_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ack_en,
	input wire logic irq_to_cpu,
	input wire logic [15:0] vector_addr,
	output logic cpu_ack,
	output logic [15:0] taken_vec
);
	timeunit 1ns;
	timeprecision 1ns;
	// ================================================================
	// accept
	// busy stops a second ack while irq still falls after the first
	logic busy;
	always_ff @(posedge aclk) begin
		cpu_ack <= 1'b0;
		if (!aresetn) begin
			busy <= 1'b0;
			taken_vec <= 16'h0000;
		end else if (!irq_to_cpu) begin
			busy <= 1'b0;
		end else if (ack_en && !busy) begin
			cpu_ack <= 1'b1;
			busy <= 1'b1;
			taken_vec <= vector_addr;
		end
	end
endmodule
`default_nettype wire

// file: tb/pvic_top_checker.sv
// assertion checker for the vectored interrupt controller
`default_nettype none
module pvic_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wdt_req,
	input wire logic posc_fail_req,
	input wire logic wosc_fail_req,
	input wire logic illegal_instr_req,
	input wire logic disable_irq_instr,
	input wire logic trap_instr,
	input wire logic cpu_ack,
	input wire logic irq_to_cpu,
	input wire logic [15:0] vector_addr,
	input wire logic [7:0] vector_byte_even,
	input wire logic [7:0] vector_byte_odd,
	input wire logic vector_valid,
	input wire logic global_irq_enable
);
	// ================================================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic kill;
	assign kill = disable_irq_instr | trap_instr | posc_fail_req
		| wosc_fail_req | illegal_instr_req;
	a_byte_even: assert property (
		vector_byte_even == vector_addr[15:8]) else $error("even byte");
	a_byte_odd: assert property (
		vector_byte_odd == vector_addr[7:0]) else $error("odd byte");
	a_reset_vec: assert property ($rose(aresetn) |->
		vector_addr == 16'h0002 && !global_irq_enable) else $error("reset");
	a_wdt_first: assert property (
		wdt_req |-> ##2 vector_addr == 16'h0004) else $error("watchdog");
	a_gie_gates_irq: assert property (
		!global_irq_enable |=> !irq_to_cpu) else $error("irq while off");
	a_valid_irq: assert property (
		vector_valid == irq_to_cpu) else $error("valid differs");
	a_irq_has_vec: assert property (
		irq_to_cpu |-> vector_addr != 16'h0000) else $error("no vector");
	a_ack_clears: assert property (
		cpu_ack && vector_valid |=> !global_irq_enable) else $error("ack");
	a_event_clears: assert property (
		kill |=> !global_irq_enable) else $error("enable kept");
	c_ack: cover property (cpu_ack && vector_valid);
	c_irq: cover property ($rose(irq_to_cpu));
	c_wdt: cover property (wdt_req);
endmodule
bind pvic_top pvic_top_checker u_chk (.*);
`default_nettype wire

// file: tb/test_prioritized_vector_interrupt_ctrl.sv
// testbench for the vectored interrupt controller
`default_nettype none
module test_prioritized_vector_interrupt_ctrl import pvic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ================================================================
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic disable_irq_instr = 1'b0, trap_instr = 1'b0, ack_en = 1'b0;
	logic [22:0] src = 23'h0;
	logic wdt_req, posc_fail_req, wosc_fail_req, illegal_instr_req;
	logic timer1_req, timer0_req, uart_rx_req, uart_tx_req, adc_req, cmp_req;
	logic [7:0] porta_pinx_req;
	logic [3:2] portd_pinx_req;
	logic [3:1] portc_pinx_req;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cpu_ack, irq_to_cpu, vector_valid, global_irq_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [15:0] vector_addr, taken_vec;
	logic [7:0] vector_byte_even, vector_byte_odd;
	int miscompares = 0;
	int tests_run = 0;
	// one row per source bit of src, expected vector beside it
	localparam logic [15:0] VECS [23] = '{16'h0004, 16'h003a, 16'h003c,
		16'h0006, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0016,
		16'h0026, 16'h0024, 16'h0022, 16'h0020, 16'h001e, 16'h001c,
		16'h001a, 16'h0018, 16'h001a, 16'h0022, 16'h0020, 16'h0034,
		16'h0032, 16'h0030};
	assign {portc_pinx_req, portd_pinx_req, cmp_req, porta_pinx_req, adc_req,
		uart_tx_req, uart_rx_req, timer0_req, timer1_req, illegal_instr_req,
		wosc_fail_req, posc_fail_req, wdt_req} = src;
	pvic_top u_dut (.*);
	pvic_cpu_model u_cpu (.*);
	always #50 aclk = ~aclk;
`define CHK(a, b) begin \
	tests_run++; \
	if ((a) !== (b)) begin \
		miscompares++; \
		$display("unexpected at %0t: got %h want %h", $time, a, b); \
	end \
end
	// ================================================================
	// tasks
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic axw(input logic [13:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [13:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input logic [22:0] v);
		@(posedge aclk);
		src <= v;
		@(posedge aclk);
		src <= 23'h0;
	endtask
	// enable, let the core take one interrupt, compare its vector
	task automatic service(input logic [15:0] exp);
		int n;
		axw(ADDR_CTRL, 32'h1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (cpu_ack !== 1'b1 && n < 20);
		repeat (3) @(posedge aclk);
		`CHK(taken_vec, exp)
	endtask
	// ================================================================
	// sequence
	initial begin
		#2000000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// the reset vector only stands until the first edge out of reset
		#1;
		`CHK(vector_addr, VEC_RESET)
		`CHK(global_irq_enable, 1'b0)
		axr(ADDR_PEND_ONE);
		`CHK(d[7:0], RST_PEND)
		done("reset");
		ack_en <= 1'b1;
		for (int i = 0; i < 23; i++) begin
			pulse(23'h1 << i);
			service(VECS[i]);
		end
		done("vectors");
		pulse(23'h130);
		service(16'h000a);
		service(16'h000c);
		service(16'h0016);
		axw(ADDR_PRIO_LO, 32'h5555_5955);
		pulse(23'h30);
		service(16'h000c);
		service(16'h000a);
		done("priority");
		ack_en <= 1'b0;
		pulse(23'h10010);
		axr(ADDR_PEND_ONE);
		`CHK(d[7:0], 8'h80)
		axr(ADDR_PEND_TWO);
		`CHK(d[7:0], 8'h01)
		`CHK(irq_to_cpu, 1'b0)
		axw(ADDR_PEND_ONE, 32'h05);
		axw(ADDR_PEND_TWO, 32'h0);
		`CHK(r, RESP_OKAY)
		axr(ADDR_PEND_ONE);
		`CHK(d[7:0], 8'h05)
		axr(ADDR_VECTOR);
		`CHK(d[15:0], 16'h0022)
		axw(ADDR_PEND_ONE, 32'h0);
		axr(ADDR_PEND_ONE);
		`CHK(d[7:0], 8'h00)
		axr(14'h0100);
		`CHK(r, RESP_SLVERR)
		axw(14'h0100, 32'h0);
		`CHK(r, RESP_SLVERR)
		done("pending");
		for (int k = 0; k < 2; k++) begin
			axw(ADDR_CTRL, 32'h1);
			`CHK(global_irq_enable, 1'b1)
			@(posedge aclk);
			{trap_instr, disable_irq_instr} <= 2'b01 << k;
			@(posedge aclk);
			{trap_instr, disable_irq_instr} <= 2'b00;
			@(posedge aclk);
			#1;
			`CHK(global_irq_enable, 1'b0)
		end
		axw(ADDR_CTRL, 32'h1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		`CHK(global_irq_enable, 1'b0)
		`CHK(vector_addr, VEC_RESET)
		done("disable");
		conclude();
	end
endmodule
`default_nettype wire
